// ---- logic/mcs_clock_ctrl.sv ----
`include "mcs_defines.svh"
`default_nettype none
module mcs_clock_ctrl
   import mcs_pkg::*;
#(
   parameter int WAIT_W = 16
) (
   // clock and resets
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic soft_rst,
   // register port
   input wire mcs_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // oscillator controls
   output logic pll_run,
   output logic main_run,
   output logic sub_run,
   output logic fast_rc_run,
   output mcs_src_t source_active,
   // clock configuration
   output mcs_clk_cfg_t clk_cfg,
   output logic rtc_mode_enable
);
   // refuse wait counter widths below 4 or above 24
   if (WAIT_W < 4 || WAIT_W > 24) begin : g_bad_wait_w
      $error("WAIT_W out of range");
   end
   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic [2:0] source_select_reg;
   logic pll_en_reg, sub_en_reg, main_en_reg;
   logic [2:0] base_div_reg;
   logic [1:0] bus0_div_reg, bus1_div_reg, bus2_div_reg, wdog_div_reg;
   logic bus1_gate_reg, bus2_gate_reg, bus1_rst_reg, bus2_rst_reg;
   logic guard_reg;
   logic rtc_reg;
   logic [WAIT_W-1:0] wait_reg;
   logic [2:0] active_reg;
   logic [2:0] ready_reg;
   logic [2:0] hold_reg;
   logic [3:0] sw_cnt_reg;
   logic [WAIT_W-1:0] cnt_reg [3];
   logic wr_en;
   logic [15:0] wait_wr;
   // wait byte duplicated into both halves of the count
   assign wait_wr = {bus_req.wdata, bus_req.wdata};
   // soft reset deliberately has no effect on any register here
   assign wr_en = bus_req.wr;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   function automatic logic legal_src(input logic [2:0] c);
      legal_src = (c == 3'h0) || (c == 3'h1) || (c == 3'h2) || (c == 3'h4) || (c == 3'h5);
   endfunction : legal_src

   function automatic logic slow_src(input logic [2:0] c);
      slow_src = c[2];
   endfunction : slow_src
   // ----------------------------------------
   // mode control
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         source_select_reg <= 3'h0;
         pll_en_reg <= 1'b0;
         sub_en_reg <= 1'b0;
         main_en_reg <= 1'b0;
      end else if (wr_en && hit(bus_req.addr, `MCS_OFF_MODE_CTL)) begin
         if (legal_src(bus_req.wdata[`MCS_SRC_HI:`MCS_SRC_LO])) begin
            source_select_reg <= bus_req.wdata[`MCS_SRC_HI:`MCS_SRC_LO];
         end
         pll_en_reg <= bus_req.wdata[`MCS_PLL_BIT];
         sub_en_reg <= bus_req.wdata[`MCS_SUB_BIT];
         main_en_reg <= bus_req.wdata[`MCS_MAIN_BIT];
      end
   end
   // fast sources held stopped while a slow source runs, until selector rewritten
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_reg <= 3'h0;
      end else if (wr_en && hit(bus_req.addr, `MCS_OFF_MODE_CTL)) begin
         hold_reg <= 3'h0;
      end else if (slow_src(active_reg) && slow_src(source_select_reg)) begin
         hold_reg <= 3'h7;
      end else if (!slow_src(active_reg)) begin
         // back on a fast source: never leave the hold stuck
         hold_reg <= 3'h0;
      end
   end
   // ----------------------------------------
   // divider registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         base_div_reg <= 3'h0;
         bus0_div_reg <= 2'h0;
         bus1_div_reg <= 2'h0;
         bus2_div_reg <= 2'h0;
         bus1_gate_reg <= 1'b1;
         bus2_gate_reg <= 1'b1;
         bus1_rst_reg <= 1'b0;
         bus2_rst_reg <= 1'b0;
         wdog_div_reg <= 2'h0;
         guard_reg <= 1'b1;
         wait_reg <= WAIT_W'(`MCS_RST_WAIT);
      end else if (wr_en) begin
         if (hit(bus_req.addr, `MCS_OFF_BASE_DIV) && bus_req.wdata[2:0] != 3'h7) begin
            base_div_reg <= bus_req.wdata[2:0];
         end
         if (hit(bus_req.addr, `MCS_OFF_BUS0_DIV)) begin
            bus0_div_reg <= bus_req.wdata[1:0];
         end
         if (hit(bus_req.addr, `MCS_OFF_BUS1_CTL)) begin
            bus1_div_reg <= bus_req.wdata[1:0];
            bus1_gate_reg <= bus_req.wdata[`MCS_GATE_BIT];
            bus1_rst_reg <= bus_req.wdata[`MCS_BRST_BIT];
         end
         if (hit(bus_req.addr, `MCS_OFF_BUS2_CTL)) begin
            bus2_div_reg <= bus_req.wdata[1:0];
            bus2_gate_reg <= bus_req.wdata[`MCS_GATE_BIT];
            bus2_rst_reg <= bus_req.wdata[`MCS_BRST_BIT];
         end
         if (hit(bus_req.addr, `MCS_OFF_WDOG_DIV)) begin
            wdog_div_reg <= bus_req.wdata[1:0];
            guard_reg <= bus_req.wdata[`MCS_GUARD_BIT];
         end
         if (hit(bus_req.addr, `MCS_OFF_WAIT_CFG)) begin
            wait_reg <= WAIT_W'(wait_wr);
         end
      end
   end
   // ----------------------------------------
   // rtc mode enable
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rtc_reg <= 1'b0;
      end else if (wr_en && hit(bus_req.addr, `MCS_OFF_RTC_CTL)) begin
         if (!bus_req.wdata[0]) begin
            rtc_reg <= 1'b0;
         end else if (ready_reg[1]) begin
            rtc_reg <= 1'b1;
         end
      end
   end
   // ----------------------------------------
   // oscillator run and stabilisation counters
   // ----------------------------------------
   logic [2:0] run_req;
   // index 0 main, 1 sub, 2 pll
   assign run_req[0] = main_en_reg && !hold_reg[0];
   assign run_req[1] = sub_en_reg || rtc_reg;
   assign run_req[2] = pll_en_reg && !hold_reg[2];
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_osc
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               cnt_reg[gi] <= '0;
               ready_reg[gi] <= 1'b0;
            end else if (!run_req[gi]) begin
               cnt_reg[gi] <= '0;
               ready_reg[gi] <= (gi == 1) && rtc_reg;
            end else if (!ready_reg[gi]) begin
               if (cnt_reg[gi] >= wait_reg) begin
                  ready_reg[gi] <= 1'b1;
               end else begin
                  cnt_reg[gi] <= cnt_reg[gi] + 1'b1;
               end
            end
         end
      end
   endgenerate
   assign main_run = run_req[0];
   assign sub_run = run_req[1];
   assign pll_run = run_req[2];
   assign fast_rc_run = !hold_reg[1];
   // ----------------------------------------
   // source switch
   // ----------------------------------------
   logic target_ok;
   always_comb begin
      case (source_select_reg)
         3'h1: target_ok = ready_reg[0];
         3'h2: target_ok = ready_reg[2];
         3'h5: target_ok = ready_reg[1];
         default: target_ok = 1'b1;
      endcase
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         active_reg <= 3'h0;
         sw_cnt_reg <= 4'h0;
      end else if (source_select_reg == active_reg || !target_ok) begin
         sw_cnt_reg <= 4'h0;
      end else if (sw_cnt_reg >= 4'(`MCS_SWITCH_CYC)) begin
         active_reg <= source_select_reg;
         sw_cnt_reg <= 4'h0;
      end else begin
         sw_cnt_reg <= sw_cnt_reg + 4'h1;
      end
   end
   assign source_active = mcs_src_t'(active_reg);
   // ----------------------------------------
   // outputs and read port
   // ----------------------------------------
   always_comb begin
      clk_cfg.base_div_sel = base_div_reg;
      clk_cfg.bus0_div_sel = bus0_div_reg;
      clk_cfg.bus1_div_sel = bus1_div_reg;
      clk_cfg.bus2_div_sel = bus2_div_reg;
      clk_cfg.wdog_div_sel = wdog_div_reg;
      clk_cfg.bus1_clk_gate = bus1_gate_reg;
      clk_cfg.bus2_clk_gate = bus2_gate_reg;
      clk_cfg.bus1_reset_ctl = bus1_rst_reg;
      clk_cfg.bus2_reset_ctl = bus2_rst_reg;
   end
   assign rtc_mode_enable = rtc_reg;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_rdata <= 8'h00;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            `MCS_OFF_MODE_CTL: bus_rdata <= {source_select_reg, pll_en_reg, sub_en_reg,
                                              1'b0, main_en_reg, 1'b0};
            `MCS_OFF_MODE_STS: bus_rdata <= {active_reg, ready_reg[2], ready_reg[1],
                                              1'b0, ready_reg[0], 1'b0};
            `MCS_OFF_BASE_DIV: bus_rdata <= {5'h00, base_div_reg};
            `MCS_OFF_BUS0_DIV: bus_rdata <= {6'h00, bus0_div_reg};
            `MCS_OFF_BUS1_CTL: bus_rdata <= {bus1_gate_reg, 2'h0, bus1_rst_reg, 2'h0,
                                              bus1_div_reg};
            `MCS_OFF_BUS2_CTL: bus_rdata <= {bus2_gate_reg, 2'h0, bus2_rst_reg, 2'h0,
                                              bus2_div_reg};
            `MCS_OFF_WDOG_DIV: bus_rdata <= {guard_reg, 5'h00, wdog_div_reg};
            `MCS_OFF_WAIT_CFG: bus_rdata <= wait_reg[7:0];
            `MCS_OFF_RTC_CTL: bus_rdata <= {7'h00, rtc_reg};
            default: bus_rdata <= 8'h00;
         endcase
      end else begin
         bus_rdata <= 8'h00;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_RDY_NEEDS_RUN: assert property (@(posedge core_clk) disable iff (!arst_n)
      !run_req[0] |=> !ready_reg[0]) else $error("main ready without run");
   AST_PLL_RDY_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
      !pll_en_reg |=> !ready_reg[2]) else $error("pll ready while disabled");
   AST_RDY_AFTER_WAIT: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(ready_reg[0]) |-> $past(cnt_reg[0] >= wait_reg)) else $error("early ready");
   AST_ACTIVE_LEGAL: assert property (@(posedge core_clk) disable iff (!arst_n)
      legal_src(active_reg)) else $error("illegal active source");
   AST_SWITCH_READY: assert property (@(posedge core_clk) disable iff (!arst_n)
      $changed(active_reg) && active_reg == 3'h2 |-> $past(ready_reg[2]))
      else $error("switched to unready pll");
   AST_RTC_NEEDS_SUB: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(rtc_reg) |-> $past(ready_reg[1])) else $error("rtc set without sub ready");
   AST_RTC_SUB_ON: assert property (@(posedge core_clk) disable iff (!arst_n)
      rtc_reg |-> sub_run) else $error("sub stopped in rtc mode");
   AST_BASE_LEGAL: assert property (@(posedge core_clk) disable iff (!arst_n)
      base_div_reg != 3'h7) else $error("forbidden base divider");
   AST_SOFT_RST_KEEP: assert property (@(posedge core_clk) disable iff (!arst_n)
      soft_rst && !bus_req.wr |=> $stable(source_select_reg) && $stable(bus1_gate_reg))
      else $error("soft reset changed registers");

   // ----------------------------------------
   // ready and hold checks
   // ----------------------------------------
   AST_SUB_RDY_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
      !run_req[1] |=> !ready_reg[1])
      else $error("sub ready while stopped");
   AST_MAIN_RDY_DROP: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(ready_reg[0]) |-> $past(!run_req[0]))
      else $error("main ready dropped while running");
   AST_PLL_RDY_WAIT: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(ready_reg[2]) |-> $past(cnt_reg[2] >= wait_reg))
      else $error("early pll ready");
   AST_SUB_RDY_WAIT: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(ready_reg[1]) && !rtc_reg |-> $past(cnt_reg[1] >= wait_reg))
      else $error("early sub ready");
   AST_HOLD_STOPS_MAIN: assert property (@(posedge core_clk) disable iff (!arst_n)
      hold_reg[0] |-> !main_run)
      else $error("main running while held");
   AST_HOLD_STOPS_PLL: assert property (@(posedge core_clk) disable iff (!arst_n)
      hold_reg[2] |-> !pll_run)
      else $error("pll running while held");
   AST_HOLD_IN_SLOW: assert property (@(posedge core_clk) disable iff (!arst_n)
      slow_src(active_reg) && slow_src(source_select_reg)
      && !(wr_en && hit(bus_req.addr, `MCS_OFF_MODE_CTL)) |=> hold_reg == 3'h7)
      else $error("fast sources not held in slow mode");
   AST_FAST_RC_FREE: assert property (@(posedge core_clk) disable iff (!arst_n)
      !slow_src(active_reg) && !(wr_en && hit(bus_req.addr, `MCS_OFF_MODE_CTL))
      |=> fast_rc_run)
      else $error("fast rc held on fast source");

   // ----------------------------------------
   // switch checks
   // ----------------------------------------
   AST_ACTIVE_TO_SEL: assert property (@(posedge core_clk) disable iff (!arst_n)
      $changed(active_reg) |-> active_reg == $past(source_select_reg))
      else $error("active source not the selected one");
   AST_MAIN_SWITCH_READY: assert property (@(posedge core_clk) disable iff (!arst_n)
      $changed(active_reg) && active_reg == 3'h1 |-> $past(ready_reg[0]))
      else $error("switched to unready main");
   AST_SUB_SWITCH_READY: assert property (@(posedge core_clk) disable iff (!arst_n)
      $changed(active_reg) && active_reg == 3'h5 |-> $past(ready_reg[1]))
      else $error("switched to unready sub");
   AST_ACTIVE_SETTLED: assert property (@(posedge core_clk) disable iff (!arst_n)
      source_select_reg == active_reg |=> $stable(active_reg))
      else $error("active source moved without request");
   AST_SW_CNT_BOUND: assert property (@(posedge core_clk) disable iff (!arst_n)
      sw_cnt_reg <= 4'(`MCS_SWITCH_CYC))
      else $error("switch counter overrun");

   // ----------------------------------------
   // register write and read port checks
   // ----------------------------------------
   AST_SEL_KEEP_FORBIDDEN: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_en && hit(bus_req.addr, `MCS_OFF_MODE_CTL)
      && !legal_src(bus_req.wdata[`MCS_SRC_HI:`MCS_SRC_LO]) |=> $stable(source_select_reg))
      else $error("forbidden source code stored");
   AST_BASE_KEEP_FORBIDDEN: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_en && hit(bus_req.addr, `MCS_OFF_BASE_DIV) && bus_req.wdata[2:0] == 3'h7
      |=> $stable(base_div_reg))
      else $error("forbidden base code stored");
   AST_BUS1_GATE_WR: assert property (@(posedge core_clk) disable iff (!arst_n)
      $changed(bus1_gate_reg) |-> $past(wr_en && hit(bus_req.addr, `MCS_OFF_BUS1_CTL)))
      else $error("bus1 gate changed without write");
   AST_BUS2_GATE_WR: assert property (@(posedge core_clk) disable iff (!arst_n)
      $changed(bus2_gate_reg) |-> $past(wr_en && hit(bus_req.addr, `MCS_OFF_BUS2_CTL)))
      else $error("bus2 gate changed without write");
   AST_WDOG_DIV_WR: assert property (@(posedge core_clk) disable iff (!arst_n)
      $changed(wdog_div_reg) |-> $past(wr_en && hit(bus_req.addr, `MCS_OFF_WDOG_DIV)))
      else $error("watchdog divider changed without write");
   AST_RTC_FALL_WR: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(rtc_reg) |-> $past(wr_en && hit(bus_req.addr, `MCS_OFF_RTC_CTL)))
      else $error("rtc mode dropped without write");
   AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
      !bus_req.rd |=> bus_rdata == 8'h00)
      else $error("read data outside read slot");

   // ----------------------------------------
   // cover points
   // ----------------------------------------
   COV_SLOW_SWITCH: cover property (@(posedge core_clk) disable iff (!arst_n)
      $changed(active_reg) && active_reg == 3'h4);
   COV_PLL_SWITCH: cover property (@(posedge core_clk) disable iff (!arst_n)
      $changed(active_reg) && active_reg == 3'h2);
   COV_SUB_SWITCH: cover property (@(posedge core_clk) disable iff (!arst_n)
      $changed(active_reg) && active_reg == 3'h5);
   COV_RTC_SET: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(rtc_reg));
   COV_MAIN_SWITCH: cover property (@(posedge core_clk) disable iff (!arst_n)
      $changed(active_reg) && active_reg == 3'h1);
endmodule : mcs_clock_ctrl
`default_nettype wire

// ---- logic/mcs_defines.svh ----
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MCS_OFF_MODE_CTL 8'h00
`define MCS_OFF_MODE_STS 8'h04
`define MCS_OFF_BASE_DIV 8'h08
`define MCS_OFF_BUS0_DIV 8'h0C
`define MCS_OFF_BUS1_CTL 8'h10
`define MCS_OFF_BUS2_CTL 8'h14
`define MCS_OFF_WDOG_DIV 8'h18
`define MCS_OFF_WAIT_CFG 8'h1C
`define MCS_OFF_RTC_CTL 8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define MCS_SRC_HI 7
`define MCS_SRC_LO 5
`define MCS_PLL_BIT 4
`define MCS_SUB_BIT 3
`define MCS_MAIN_BIT 1
`define MCS_GATE_BIT 7
`define MCS_BRST_BIT 4
`define MCS_GUARD_BIT 7
// ----------------------------------------
// reset values
// ----------------------------------------
`define MCS_RST_BUS_CTL 8'h80
`define MCS_RST_WAIT 16'h0010
// ----------------------------------------
// timing
// ----------------------------------------
`define MCS_SWITCH_NS 16
`define MCS_SWITCH_CYC ((`MCS_SWITCH_NS + 7) / 8)
`endif

// ---- logic/mcs_pkg.sv ----
`default_nettype none
package mcs_pkg;
   typedef enum logic [2:0] {
      MCS_SRC_FAST_RC = 3'h0,
      MCS_SRC_MAIN = 3'h1,
      MCS_SRC_PLL = 3'h2,
      MCS_SRC_SLOW_RC = 3'h4,
      MCS_SRC_SUB = 3'h5
   } mcs_src_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mcs_bus_req_t;
   typedef struct packed {
      logic [2:0] base_div_sel;
      logic [1:0] bus0_div_sel;
      logic [1:0] bus1_div_sel;
      logic [1:0] bus2_div_sel;
      logic [1:0] wdog_div_sel;
      logic bus1_clk_gate;
      logic bus2_clk_gate;
      logic bus1_reset_ctl;
      logic bus2_reset_ctl;
   } mcs_clk_cfg_t;
endpackage : mcs_pkg
`default_nettype wire

// ---- dv/mcs_clock_ctrl_tb.sv ----
`include "mcs_defines.svh"
`default_nettype none
module mcs_clock_ctrl_tb
   import mcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic soft_rst = 1'b0;
   mcs_bus_req_t req = '0;
   logic [7:0] rdata;
   logic pll_run, main_run, sub_run, fast_rc_run, rtc_on;
   mcs_src_t src;
   mcs_clk_cfg_t cfg;
   int err_count = 0;
   int n_compared = 0;
   always #4 core_clk = ~core_clk;
   mcs_clock_ctrl mcs_clock_ctrl_inst (
      .core_clk(core_clk), .arst_n(arst_n), .soft_rst(soft_rst), .bus_req(req),
      .bus_rdata(rdata), .pll_run(pll_run), .main_run(main_run), .sub_run(sub_run),
      .fast_rc_run(fast_rc_run), .source_active(src), .clk_cfg(cfg),
      .rtc_mode_enable(rtc_on)
   );
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      req.wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      req.rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(v, exp);
   endtask : rd_chk
   task automatic poll_sts(input logic [7:0] mask);
      logic [7:0] v;
      v = 8'h00;
      for (int i = 0; i < 64 && (v & mask) != mask; i++) rd(`MCS_OFF_MODE_STS, v);
      chk(v & mask, mask);
   endtask : poll_sts
   task automatic wait_src(input mcs_src_t s);
      for (int i = 0; i < 20 && src !== s; i++) @(posedge core_clk) #1;
      chk({5'h00, src}, {5'h00, s});
   endtask : wait_src
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_values();
      rd_chk(`MCS_OFF_MODE_CTL, 8'h00);
      rd_chk(`MCS_OFF_MODE_STS, 8'h00);
      rd_chk(`MCS_OFF_BASE_DIV, 8'h00);
      rd_chk(`MCS_OFF_BUS0_DIV, 8'h00);
      rd_chk(`MCS_OFF_BUS1_CTL, 8'h80);
      rd_chk(`MCS_OFF_BUS2_CTL, 8'h80);
      rd_chk(`MCS_OFF_WDOG_DIV, 8'h80);
      rd_chk(`MCS_OFF_WAIT_CFG, 8'h10);
      rd_chk(8'h30, 8'h00);
      chk({6'h00, cfg.bus1_clk_gate, cfg.bus2_clk_gate}, 8'h03);
   endtask : t_reset_values
   task automatic t_osc_switch();
      wr(`MCS_OFF_MODE_CTL, 8'h02);
      chk({7'h00, main_run}, 8'h01);
      rd_chk(`MCS_OFF_MODE_STS, 8'h00);
      poll_sts(8'h02);
      wr(`MCS_OFF_MODE_CTL, 8'h22);
      chk({5'h00, src}, {5'h00, MCS_SRC_FAST_RC});
      wait_src(MCS_SRC_MAIN);
      rd_chk(`MCS_OFF_MODE_STS, 8'h22);
      wr(`MCS_OFF_MODE_CTL, 8'h02);
      wait_src(MCS_SRC_FAST_RC);
      wr(`MCS_OFF_MODE_CTL, 8'h00);
      chk({7'h00, main_run}, 8'h00);
      rd_chk(`MCS_OFF_MODE_STS, 8'h00);
      wr(`MCS_OFF_MODE_CTL, 8'h10);
      chk({7'h00, pll_run}, 8'h01);
      poll_sts(8'h10);
      wr(`MCS_OFF_MODE_CTL, 8'h50);
      wait_src(MCS_SRC_PLL);
      rd_chk(`MCS_OFF_MODE_STS, 8'h50);
      wr(`MCS_OFF_MODE_CTL, 8'h10);
      wait_src(MCS_SRC_FAST_RC);
   endtask : t_osc_switch
   task automatic t_forbidden_sel();
      wr(`MCS_OFF_MODE_CTL, 8'h70);
      rd_chk(`MCS_OFF_MODE_CTL, 8'h10);
      wr(`MCS_OFF_MODE_CTL, 8'hD0);
      wr(`MCS_OFF_MODE_CTL, 8'hF0);
      rd_chk(`MCS_OFF_MODE_CTL, 8'h10);
      chk({5'h00, src}, {5'h00, MCS_SRC_FAST_RC});
      wr(`MCS_OFF_MODE_CTL, 8'h00);
      chk({7'h00, pll_run}, 8'h00);
   endtask : t_forbidden_sel
   task automatic t_dividers();
      for (int c = 0; c < 7; c++) begin
         wr(`MCS_OFF_BASE_DIV, 8'(c));
         chk({5'h00, cfg.base_div_sel}, 8'(c));
      end
      wr(`MCS_OFF_BASE_DIV, 8'h07);
      rd_chk(`MCS_OFF_BASE_DIV, 8'h06);
      wr(`MCS_OFF_BUS0_DIV, 8'h03);
      chk({6'h00, cfg.bus0_div_sel}, 8'h03);
      wr(`MCS_OFF_BUS1_CTL, 8'h12);
      chk({4'h0, cfg.bus1_clk_gate, cfg.bus1_reset_ctl, cfg.bus1_div_sel}, 8'h06);
      wr(`MCS_OFF_BUS2_CTL, 8'h91);
      chk({4'h0, cfg.bus2_clk_gate, cfg.bus2_reset_ctl, cfg.bus2_div_sel}, 8'h0D);
      wr(`MCS_OFF_WDOG_DIV, 8'h82);
      chk({6'h00, cfg.wdog_div_sel}, 8'h02);
      rd_chk(`MCS_OFF_BUS1_CTL, 8'h12);
   endtask : t_dividers
   task automatic t_soft_reset();
      wr(`MCS_OFF_MODE_CTL, 8'h02);
      @(posedge core_clk) soft_rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      soft_rst <= 1'b0;
      rd_chk(`MCS_OFF_MODE_CTL, 8'h02);
      rd_chk(`MCS_OFF_BASE_DIV, 8'h06);
      rd_chk(`MCS_OFF_BUS0_DIV, 8'h03);
      rd_chk(`MCS_OFF_BUS2_CTL, 8'h91);
      poll_sts(8'h02);
      wr(`MCS_OFF_MODE_CTL, 8'h00);
   endtask : t_soft_reset
   task automatic t_rtc_mode();
      wr(`MCS_OFF_RTC_CTL, 8'h01);
      chk({7'h00, rtc_on}, 8'h00);
      wr(`MCS_OFF_MODE_CTL, 8'h08);
      chk({7'h00, sub_run}, 8'h01);
      poll_sts(8'h08);
      wr(`MCS_OFF_RTC_CTL, 8'h01);
      chk({7'h00, rtc_on}, 8'h01);
      wr(`MCS_OFF_MODE_CTL, 8'h00);
      chk({7'h00, sub_run}, 8'h01);
      wr(`MCS_OFF_RTC_CTL, 8'h00);
      chk({7'h00, sub_run}, 8'h00);
   endtask : t_rtc_mode
   task automatic t_slow_hold();
      wr(`MCS_OFF_MODE_CTL, 8'h80);
      wait_src(MCS_SRC_SLOW_RC);
      rd_chk(`MCS_OFF_MODE_STS, 8'h80);
      chk({6'h00, fast_rc_run, main_run}, 8'h00);
      wr(`MCS_OFF_MODE_CTL, 8'h02);
      chk({6'h00, fast_rc_run, main_run}, 8'h03);
      wait_src(MCS_SRC_FAST_RC);
      repeat (2) @(posedge core_clk);
      #1;
      chk({7'h00, fast_rc_run}, 8'h01);
   endtask : t_slow_hold
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic end_of_test();
      $display("compared=%0d mismatches=%0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   initial begin
      #100us;
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge core_clk);
      arst_n <= 1'b1;
      t_reset_values();
      t_osc_switch();
      t_forbidden_sel();
      t_dividers();
      t_soft_reset();
      t_rtc_mode();
      t_slow_hold();
      end_of_test();
   end
endmodule : mcs_clock_ctrl_tb
`default_nettype wire
